// file: common/serdes_pcs_regs.svh
`ifndef SERDES_PCS_REGS_SVH
`define SERDES_PCS_REGS_SVH

// register indices, byte address is index times four
`define IDX_ADV        6'h12
`define IDX_PARTNER    6'h13
`define IDX_RX_STATUS  6'h14
`define IDX_GOOD_CNT   6'h15
`define IDX_CRC_CNT    6'h16
`define IDX_CTRL       6'h20
`define IDX_IRQ_STATUS 6'h21
`define IDX_IRQ_MASK   6'h22

// field positions
`define CTRL_FORCE_ADV 0
`define ST_REALIGN     15
`define ST_SIG_DET     14
`define ST_QSGMII_SYNC 13
`define ST_COMMA_DET   12
`define ST_POS_LSB     8
`define GOOD_ACTIVE    15
`define SEL_LSB        14

// reset values
`define ADV_RESET      16'h0000
`define SEL_RESET      2'h0
`define CRC_RESET      8'h00
`define GOOD_RESET     14'h0000

// counter select codes
`define SEL_MEDIA      2'h0
`define SEL_MAC        2'h1

// counter limits
`define GOOD_LAST      14'h270f
`define CRC_MAX        8'hff

`endif

// file: common/serdes_pcs_pkg.sv
package serdes_pcs_pkg;

  // serdes side inputs, all asynchronous to mclk
  typedef struct packed {
    logic        media_link_up;
    logic        qsgmii_mode;
    logic        qsgmii_sync;
    logic        comma_realign;
    logic        signal_detect;
    logic        comma_detect;
    logic [3:0]  comma_pos;
    logic        partner_valid;
    logic [15:0] partner_word;
    logic [15:0] native_word;
    logic        media_good;
    logic        media_crc;
    logic        mac_good;
    logic        mac_crc;
  } serdes_pins_t;

  // interrupt status and mask layout
  typedef struct packed {
    logic crc_sat;
    logic partner_rx;
    logic sig_det;
    logic realign;
  } irq_bits_t;

endpackage

// file: logic/serdes_pcs_bank.sv
`include "serdes_pcs_regs.svh"

// Function
// - advertised word writable only when forcing
// - advertised readback undefined unless forcing
// - latch last partner code word, read only
// - sticky realign flag, cleared by read
// - sticky signal detect flag, cleared by read
// - comma detect follows commas, read sets
// - report comma position zero through nine
// - comma position ignored in qsgmii mode
// - qsgmii sync meaningful on port zero only
// - good counter active flag reads one only with media link up and a defined select
// - good packet count wraps after 9999
// - selector picks media or mac counters
// - crc error count saturates at 255
// - counters advance only with media link up
// - forcing advertises the register word
module serdes_pcs_bank #(
  parameter bit PORT_ZERO = 1'b1
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // avalon-mm slave
  input  wire logic [7:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  // serdes side pins
  input  wire serdes_pcs_pkg::serdes_pins_t pins,
  // advertised word and interrupt
  output logic      [15:0]                 adv_word_out,
  output logic                             irq
);

  // byte lane merge for 16-bit registers
  function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be);
    be_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                be[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // rising edge of a synchronised event level
  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v & ~old_v;
  endfunction

  serdes_pcs_pkg::serdes_pins_t s1_q;
  serdes_pcs_pkg::serdes_pins_t s2_q;
  serdes_pcs_pkg::serdes_pins_t s3_q;
  serdes_pcs_pkg::irq_bits_t    irq_st_q;
  serdes_pcs_pkg::irq_bits_t    irq_st_d;
  serdes_pcs_pkg::irq_bits_t    irq_mask_q;
  serdes_pcs_pkg::irq_bits_t    irq_ev;
  serdes_pcs_pkg::irq_bits_t    irq_clr;

  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic [15:0] adv_out_q;
  logic        force_q;
  logic [15:0] partner_q;
  logic        realign_q;
  logic        sig_det_q;
  logic        comma_q;
  logic [1:0]  sel_q;
  logic [13:0] good_q;
  logic [13:0] good_d;
  logic [7:0]  crc_q;
  logic [7:0]  crc_d;

  // two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // event edges
  wire ev_realign = rise(s2_q.comma_realign, s3_q.comma_realign);
  wire ev_sig_det = rise(s2_q.signal_detect, s3_q.signal_detect);
  wire ev_partner = rise(s2_q.partner_valid, s3_q.partner_valid);
  wire ev_m_good  = rise(s2_q.media_good, s3_q.media_good);
  wire ev_m_crc   = rise(s2_q.media_crc, s3_q.media_crc);
  wire ev_c_good  = rise(s2_q.mac_good, s3_q.mac_good);
  wire ev_c_crc   = rise(s2_q.mac_crc, s3_q.mac_crc);

  // bus handshake: one wait cycle, then the request fires
  wire       req     = read | write;
  wire       rd_fire = read & ack_q;
  wire       wr_fire = write & ack_q;
  wire [5:0] idx     = address[7:2];
  assign waitrequest = req & ~ack_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) ack_q <= 1'b0;
    else         ack_q <= req & ~ack_q;
  end

  // address decode
  wire hit_adv  = idx == `IDX_ADV;
  wire hit_part = idx == `IDX_PARTNER;
  wire hit_st   = idx == `IDX_RX_STATUS;
  wire hit_good = idx == `IDX_GOOD_CNT;
  wire hit_crc  = idx == `IDX_CRC_CNT;
  wire hit_ctrl = idx == `IDX_CTRL;
  wire hit_ist  = idx == `IDX_IRQ_STATUS;
  wire hit_imsk = idx == `IDX_IRQ_MASK;
  wire rd_st    = rd_fire & hit_st;

  // status word fields
  wire [3:0] pos_rd  = s2_q.qsgmii_mode ? 4'h0 : s2_q.comma_pos;
  wire       sync_rd = PORT_ZERO ? s2_q.qsgmii_sync : 1'b0;
  wire [15:0] st_word = {realign_q, sig_det_q, sync_rd, comma_q, pos_rd, 8'h00};

  // counter enable and selected events
  wire sel_ok   = (sel_q == `SEL_MEDIA) | (sel_q == `SEL_MAC);
  wire cnt_en   = s2_q.media_link_up & sel_ok;
  wire good_ev  = (sel_q == `SEL_MEDIA) ? ev_m_good : ev_c_good;
  wire crc_ev   = (sel_q == `SEL_MEDIA) ? ev_m_crc : ev_c_crc;
  wire good_inc = cnt_en & good_ev;
  wire crc_inc  = cnt_en & crc_ev & (crc_q != `CRC_MAX);

  // readback: advertised word unless forcing is undefined, show the live word
  wire [15:0] adv_rd = force_q ? adv_q : s2_q.native_word;
  wire [15:0] rd_mux =
      hit_adv  ? adv_rd :
      hit_part ? partner_q :
      hit_st   ? st_word :
      hit_good ? {cnt_en, 1'b0, good_q} :
      hit_crc  ? {sel_q, 6'h00, crc_q} :
      hit_ctrl ? {15'h0000, force_q} :
      hit_ist  ? {12'h000, irq_st_q} :
      hit_imsk ? {12'h000, irq_mask_q} : 16'h0000;

  // read data captured in the wait cycle, stands at the firing edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)                rdata_q <= 32'h0000_0000;
    else if (read & ~ack_q)     rdata_q <= {16'h0000, rd_mux};
  end
  assign readdata = rdata_q;

  // next values of written registers
  always_comb begin
    adv_d = adv_q;
    if (wr_fire & hit_adv & force_q)
      adv_d = be_merge(adv_q, writedata[15:0], byteenable[1:0]);
    good_d = good_q;
    if (good_inc)
      good_d = (good_q == `GOOD_LAST) ? 14'h0000 : good_q + 14'h0001;
    crc_d = crc_inc ? crc_q + 8'h01 : crc_q;
  end

  // advertised word, force control and counter select
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adv_q   <= `ADV_RESET;
      force_q <= 1'b0;
      sel_q   <= `SEL_RESET;
    end else begin
      adv_q <= adv_d;
      if (wr_fire & hit_ctrl & byteenable[0])
        force_q <= writedata[`CTRL_FORCE_ADV];
      if (wr_fire & hit_crc & byteenable[1])
        sel_q <= writedata[`SEL_LSB+1:`SEL_LSB];
    end
  end

  // advertised word driven to the serdes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) adv_out_q <= `ADV_RESET;
    else         adv_out_q <= force_q ? adv_q : s2_q.native_word;
  end
  assign adv_word_out = adv_out_q;

  // partner code word capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)         partner_q <= 16'h0000;
    else if (ev_partner) partner_q <= s2_q.partner_word;
  end

  // sticky flags: only a bit that was read out is cleared, a new event wins; comma detect follows its pin, a status read sets it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      realign_q <= 1'b0;
      sig_det_q <= 1'b0;
      comma_q   <= 1'b0;
    end else begin
      realign_q <= ev_realign | (realign_q & ~(rd_st & rdata_q[`ST_REALIGN]));
      sig_det_q <= ev_sig_det | (sig_det_q & ~(rd_st & rdata_q[`ST_SIG_DET]));
      comma_q   <= s2_q.comma_detect | rd_st;
    end
  end

  // transmit counters
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      good_q <= `GOOD_RESET;
      crc_q  <= `CRC_RESET;
    end else begin
      good_q <= good_d;
      crc_q  <= crc_d;
    end
  end

  // interrupt events and write-one-to-clear
  assign irq_ev  = '{crc_sat: crc_inc & (crc_q == `CRC_MAX - 8'h01),
                     partner_rx: ev_partner,
                     sig_det: ev_sig_det,
                     realign: ev_realign};
  assign irq_clr = (wr_fire & hit_ist & byteenable[0]) ? writedata[3:0] : 4'h0;
  assign irq_st_d = irq_ev | (irq_st_q & ~irq_clr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st_q   <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
      if (wr_fire & hit_imsk & byteenable[0])
        irq_mask_q <= writedata[3:0];
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // advertised register holds while forcing is off
  property p_adv_locked;
    @(posedge mclk) disable iff (!arst_n)
      !force_q |=> $stable(adv_q);
  endproperty
  a_adv_locked: assert property (p_adv_locked) else $error("adv word changed unforced");

  // forced word reaches the serdes one cycle later
  property p_adv_out;
    @(posedge mclk) disable iff (!arst_n)
      force_q |=> adv_word_out == $past(adv_q);
  endproperty
  a_adv_out: assert property (p_adv_out) else $error("forced word not advertised");

  // partner word follows its strobe
  property p_partner;
    @(posedge mclk) disable iff (!arst_n)
      ev_partner |=> partner_q == $past(s2_q.partner_word);
  endproperty
  a_partner: assert property (p_partner) else $error("partner word not captured");

  // realign flag is still set after its event and two cycles without a status read
  property p_realign;
    @(posedge mclk) disable iff (!arst_n)
      ev_realign ##1 !rd_st [*2] |=> realign_q;
  endproperty
  a_realign: assert property (p_realign) else $error("realign flag lost");

  // signal detect flag sets on its event
  property p_sig_det;
    @(posedge mclk) disable iff (!arst_n)
      ev_sig_det |=> sig_det_q;
  endproperty
  a_sig_det: assert property (p_sig_det) else $error("signal detect flag not set");

  // status read leaves comma detect at one
  property p_comma;
    @(posedge mclk) disable iff (!arst_n)
      rd_st |=> comma_q;
  endproperty
  a_comma: assert property (p_comma) else $error("comma detect not set by read");

  // good count stays below 10000 and wraps to zero
  property p_good_wrap;
    @(posedge mclk) disable iff (!arst_n)
      good_inc && good_q == `GOOD_LAST |=> good_q == 14'h0000 ##1 good_q <= `GOOD_LAST;
  endproperty
  a_good_wrap: assert property (p_good_wrap) else $error("good count wrap wrong");

  // crc count saturates
  property p_crc_sat;
    @(posedge mclk) disable iff (!arst_n)
      crc_q == `CRC_MAX |=> crc_q == `CRC_MAX;
  endproperty
  a_crc_sat: assert property (p_crc_sat) else $error("crc count left 255");

  // no counting without media link
  property p_link;
    @(posedge mclk) disable iff (!arst_n)
      !s2_q.media_link_up |=> $stable(good_q) && $stable(crc_q);
  endproperty
  a_link: assert property (p_link) else $error("counter moved with link down");

  // a write to a read-only word changes nothing
  property p_ro_write;
    @(posedge mclk) disable iff (!arst_n)
      wr_fire && (hit_part || hit_good) && !ev_partner && !good_inc
        |=> $stable(partner_q) && $stable(good_q);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

  // comma position reads zero in qsgmii mode
  property p_qsgmii_pos;
    @(posedge mclk) disable iff (!arst_n)
      read && !ack_q && hit_st && s2_q.qsgmii_mode |=> rdata_q[11:8] == 4'h0;
  endproperty
  a_qsgmii_pos: assert property (p_qsgmii_pos) else $error("comma position shown");

  // bus answers after exactly one wait cycle
  property p_wait;
    @(posedge mclk) disable iff (!arst_n)
      $rose(req) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest timing wrong");

  // a forced full write lands in the advertised register
  property p_adv_write;
    @(posedge mclk) disable iff (!arst_n)
      wr_fire && hit_adv && force_q && byteenable[1:0] == 2'h3
        |=> adv_q == $past(writedata[15:0]);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("forced write not stored");

  // a status read that showed realign clears it unless a new one arrives
  property p_realign_clr;
    @(posedge mclk) disable iff (!arst_n)
      rd_st && rdata_q[`ST_REALIGN] && !ev_realign |=> !realign_q;
  endproperty
  a_realign_clr: assert property (p_realign_clr) else $error("realign flag not cleared");

  // a status read that showed signal detect clears it unless a new one arrives
  property p_sig_det_clr;
    @(posedge mclk) disable iff (!arst_n)
      rd_st && rdata_q[`ST_SIG_DET] && !ev_sig_det |=> !sig_det_q;
  endproperty
  a_sig_det_clr: assert property (p_sig_det_clr) else $error("signal detect not cleared");

  // comma detect drops when the pin is low and no read is firing
  property p_comma_drop;
    @(posedge mclk) disable iff (!arst_n)
      !s2_q.comma_detect && !rd_st |=> !comma_q;
  endproperty
  a_comma_drop: assert property (p_comma_drop) else $error("comma detect held");

  // active bit reads as link up with a defined select
  property p_active;
    @(posedge mclk) disable iff (!arst_n)
      read && !ack_q && hit_good
        |=> rdata_q[`GOOD_ACTIVE] == ($past(s2_q.media_link_up) && !$past(sel_q[1]));
  endproperty
  a_active: assert property (p_active) else $error("active bit wrong");

  // reserved select codes freeze both counters
  property p_sel_rsvd;
    @(posedge mclk) disable iff (!arst_n)
      sel_q[1] |=> $stable(good_q) && $stable(crc_q);
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("counted on reserved select");

  // good count steps by one below the wrap point
  property p_good_step;
    @(posedge mclk) disable iff (!arst_n)
      good_inc && good_q != `GOOD_LAST |=> good_q == $past(good_q) + 14'h0001;
  endproperty
  a_good_step: assert property (p_good_step) else $error("good count step wrong");

  // crc count steps by one below saturation
  property p_crc_step;
    @(posedge mclk) disable iff (!arst_n)
      crc_inc |=> crc_q == $past(crc_q) + 8'h01;
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("crc count step wrong");

  // qsgmii sync is shown only on port zero
  property p_sync_port;
    @(posedge mclk) disable iff (!arst_n)
      read && !ack_q && hit_st
        |=> rdata_q[`ST_QSGMII_SYNC] == (PORT_ZERO && $past(s2_q.qsgmii_sync));
  endproperty
  a_sync_port: assert property (p_sync_port) else $error("qsgmii sync shown wrongly");

endmodule

// file: verification/serdes_link_model.sv
// far side of the serdes pins: events are pulses of two high, two low cycles
module serdes_link_model (
  // clock
  input  wire logic                   mclk,
  // pins towards the bank
  output serdes_pcs_pkg::serdes_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero
  initial begin
    pins = '0;
    pins.native_word = 16'h0f0f;
  end

  // drive all event pins at once, one bit each
  task automatic drv(input logic [6:0] m);
    {pins.mac_crc, pins.mac_good, pins.media_crc, pins.media_good,
     pins.partner_valid, pins.signal_detect, pins.comma_realign} <= m;
  endtask

  // n rising edges on every event pin in the mask
  task automatic pulse(input logic [6:0] m, input int n);
    repeat (n) begin
      @(posedge mclk) drv(m);
      @(posedge mclk);
      @(posedge mclk) drv(7'h00);
      @(posedge mclk);
    end
  endtask

  // code word stable before the strobe, scrambled once released
  task automatic send_word(input logic [15:0] w);
    @(posedge mclk) pins.partner_word <= w;
    repeat (3) @(posedge mclk);
    pulse(7'h04, 1);
    pins.partner_word <= ~w;
  endtask
endmodule

// file: verification/tb_serdes_pcs_ability_status_counters.sv
module tb_serdes_pcs_ability_status_counters;
  timeunit 1ns;
  timeprecision 1ps;

  logic                         mclk;
  logic                         arst_n;
  logic [7:0]                   address;
  logic                         read;
  logic                         write;
  logic [31:0]                  writedata;
  logic [31:0]                  readdata;
  logic                         waitrequest;
  serdes_pcs_pkg::serdes_pins_t pins;
  logic [15:0]                  adv_word_out;
  logic                         irq;
  int                           fails;
  int                           compares;
  int                           cyc;

  serdes_pcs_bank #(.PORT_ZERO(1'b1)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .pins(pins),
    .adv_word_out(adv_word_out), .irq(irq));

  serdes_link_model i_lp (.mclk(mclk), .pins(pins));

  // clock and run limit
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {16'h0000, d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(n, e, q);
  endtask

  // reset values and an unmapped place
  task automatic t_reset;
    rd(8'h58, 32'h0000_0000, "crc_reg");
    rd(8'h54, 32'h0000_0000, "good_reg");
    rd(8'h3c, 32'h0000_0000, "unmapped");
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // advertised word locked until forcing, then driven out
  task automatic t_adv;
    wr(8'h48, 16'h1234);
    wr(8'h80, 16'h0001);
    rd(8'h48, 32'h0000_0000, "adv_locked");
    wr(8'h48, 16'ha5c3);
    rd(8'h48, 32'h0000_a5c3, "adv_reg");
    chk("adv_out", 32'ha5c3, {16'h0, adv_word_out});
  endtask

  // partner word capture, read only
  task automatic t_partner;
    i_lp.send_word(16'hbeef);
    repeat (4) @(posedge mclk);
    rd(8'h4c, 32'h0000_beef, "partner");
    wr(8'h4c, 16'h0000);
    rd(8'h4c, 32'h0000_beef, "partner_ro");
  endtask

  // sticky flags, clear on read, irq raise, mask and clear
  task automatic t_status;
    wr(8'h88, 16'h0001);
    i_lp.pulse(7'h03, 1);
    repeat (4) @(posedge mclk);
    chk("irq_up", 32'h1, {31'h0, irq});
    rd(8'h50, 32'h0000_f900, "status");
    rd(8'h50, 32'h0000_3900, "status_clr");
    wr(8'h84, 16'h0001);
    repeat (2) @(posedge mclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask

  // counters: link gating, select, wrap, saturation
  task automatic t_count;
    wr(8'h58, 16'h40ff);
    rd(8'h58, 32'h0000_4000, "sel_mac");
    i_lp.pulse(7'h60, 1);
    rd(8'h54, 32'h0000_0000, "link_down");
    @(posedge mclk) i_lp.pins.media_link_up <= 1'b1;
    repeat (4) @(posedge mclk);
    i_lp.pulse(7'h60, 3);
    i_lp.pulse(7'h18, 1);
    repeat (4) @(posedge mclk);
    rd(8'h54, 32'h0000_8003, "good_mac");
    rd(8'h58, 32'h0000_4003, "crc_mac");
    wr(8'h58, 16'h0000);
    i_lp.pulse(7'h18, 9997);
    repeat (4) @(posedge mclk);
    rd(8'h54, 32'h0000_8000, "good_wrap");
    rd(8'h58, 32'h0000_00ff, "crc_sat");
    wr(8'h88, 16'h0008);
    repeat (2) @(posedge mclk);
    chk("irq_sat", 32'h1, {31'h0, irq});
    wr(8'h58, 16'h8000);
    i_lp.pulse(7'h18, 1);
    repeat (4) @(posedge mclk);
    rd(8'h54, 32'h0000_0000, "sel_rsvd");
  endtask

  // qsgmii mode hides the comma position, comma detect follows its pin
  task automatic t_mode;
    @(posedge mclk) begin
      i_lp.pins.qsgmii_mode <= 1'b1;
      i_lp.pins.comma_detect <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    rd(8'h50, 32'h0000_2000, "status_qsgmii");
    @(posedge mclk) i_lp.pins.comma_detect <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h50, 32'h0000_3000, "status_comma");
  endtask

  // main sequence
  initial begin
    arst_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    i_lp.pins.qsgmii_sync <= 1'b1;
    i_lp.pins.comma_detect <= 1'b1;
    i_lp.pins.comma_pos <= 4'h9;
    repeat (2) @(posedge mclk);
    t_reset();
    t_adv();
    t_partner();
    t_status();
    t_count();
    t_mode();
    report_and_stop();
  end
endmodule
